// file: logic/adc_conversion_control.sv
// Conversion control around a 10-bit successive-approximation converter.
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// How it works
// R01: Idle and software-stop standby halt conversion; halt standby keeps converting.
// R02: Clearing mode bit 7 stops any conversion and powers the converter down.
// R03: A result read coinciding with the result write returns the old value.
// R04: Trigger edges are ignored during conversion, including the result-write cycle; the code is already waiting then and takes an edge on the commit edge.
// R05: Mode or channel write right after result write discards result, no request.
// R06: Writing the channel register leaves the conversion-done flag untouched.
// R07: A conversion finishing just before a channel write neither stores nor flags.
// R08: Software should clear the done flag before restarting stopped conversions.
// R09: Mode or channel writes may spoil the result; read only while running.
// R10: Each conversion yields a 10-bit code, one step per 1/1024 of reference.
// R11: Counted conversion time includes the sampling phase up to result ready.
// R12: Software-start mode converts back to back while bit 7 stays set.
// R13: With bits 6 and 7 set, one conversion per external trigger edge.
// R14: Mode or channel write aborts conversion and restarts if still running.
// R15: Software keeps channel upper bits zero and selects inputs 0 to 11.
// R16: End of conversion moves the value to the result and pulses done together.
// R17: One result bit per step, MSB first, over a fixed step period.
module adc_conversion_control
  import adc_ctrl_pkg::*;
(
  input  wire logic       clk_sys_i,      // System clock, 200 MHz.
  input  wire logic       rst_i,          // Asynchronous reset, active high.
  input  wire reg_req_t   req_i,          // Register port request.
  output logic [7:0]      rdata_o,        // Read data, valid the cycle after a read.
  input  wire logic       standby_stop_i, // Idle or software-stop standby active.
  input  wire logic       ext_trigger_i,  // External trigger pin.
  input  wire logic       cmp_above_i,    // Comparator: input at or above the tap.
  output afe_ctl_t        afe_o,          // Analog front-end controls.
  output logic            done_irq_o,     // Conversion-done request pulse.
  output logic            done_flag_o     // Sticky conversion-done flag.
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [7:0]  converter_mode_reg;
  logic [7:0]  channel_select_reg;
  logic [9:0]  conversion_result_reg;
  logic        conversion_done_flag;
  logic [9:0]  approximation_shift_reg;
  logic [9:0]  probe_bit;
  seq_state_t  state;
  logic [7:0]  cycle_cnt;
  logic        trig_meta;
  logic        trig_sync;
  logic        trig_prev;
  logic        standby_meta;
  logic        standby_sync;
  logic        eoc_pending;
  logic [9:0]  pending_value;
  logic        cfg_write;
  logic        run_ok;
  logic        trig_edge;
  logic        step_end;
  logic        conv_end;
  logic [9:0]  next_sar;
  logic        trig_mode_next;

  ////////////////////////////////////////////////////////////////////////////
  // Decodes and conditions.

  // A mode or channel write reconfigures the sequencer.
  assign cfg_write = req_i.wr && (req_i.addr == OFS_MODE || req_i.addr == OFS_CHANNEL);
  // Trigger mode as it stands after this edge, so a write that turns it on waits for an edge.
  assign trig_mode_next = (req_i.wr && req_i.addr == OFS_MODE) ? req_i.wdata[MODE_TRIG_BIT]
                                                              : converter_mode_reg[MODE_TRIG_BIT];
  // Running needs bit 7 and no stopping standby; halt standby is not seen here.
  assign run_ok = converter_mode_reg[MODE_RUN_BIT] && !standby_sync; // R01 R02
  assign step_end = (cycle_cnt == 8'h00);
  assign conv_end = (state == ST_STEP) && step_end && probe_bit[0];
  // Keep the probed bit if the comparator says the input is at or above the tap.
  assign next_sar = cmp_above_i ? approximation_shift_reg
                                : (approximation_shift_reg & ~probe_bit); // R17

  // Edge detection on the synchronised trigger, per selected polarity.
  always_comb
  begin
    unique case (converter_mode_reg[MODE_EDGE_LO +: 2])
      EDGE_FALL: trig_edge = trig_prev && !trig_sync;
      EDGE_RISE: trig_edge = !trig_prev && trig_sync;
      EDGE_BOTH: trig_edge = trig_prev ^ trig_sync;
      default:   trig_edge = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers; the first stages feed only the second.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      trig_meta    <= 1'b0;
      trig_sync    <= 1'b0;
      trig_prev    <= 1'b0;
      standby_meta <= 1'b0;
      standby_sync <= 1'b0;
    end
    else
    begin
      trig_meta    <= ext_trigger_i;
      trig_sync    <= trig_meta;
      trig_prev    <= trig_sync;
      standby_meta <= standby_stop_i;
      standby_sync <= standby_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers written by software.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      converter_mode_reg <= MODE_RESET;
      channel_select_reg <= CHANNEL_RESET;
    end
    else if (req_i.wr)
    begin
      if (req_i.addr == OFS_MODE)
        converter_mode_reg <= req_i.wdata;
      if (req_i.addr == OFS_CHANNEL)
        channel_select_reg <= {4'h0, req_i.wdata[3:0]}; // R15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer: sample, then one step per result bit.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state                   <= ST_IDLE;
      cycle_cnt               <= 8'h00;
      approximation_shift_reg <= 10'h000;
      probe_bit               <= 10'h000;
    end
    else if (!run_ok)
    begin
      state     <= ST_IDLE; // R01 R02
      probe_bit <= 10'h000;
    end
    else if (cfg_write || state == ST_IDLE)
    begin
      // Abort and restart from the top; trigger mode waits for an edge.
      probe_bit <= 10'h000; // R14
      if (trig_mode_next) // R13
        state <= ST_WAIT;
      else
      begin
        state     <= ST_SAMPLE;
        cycle_cnt <= SAMPLE_LOAD;
      end
    end
    else
    begin
      unique case (state)
        ST_WAIT:
        begin
          // Edges are only looked at while waiting, never mid-conversion.
          if (trig_edge) // R04 R13
          begin
            state     <= ST_SAMPLE;
            cycle_cnt <= SAMPLE_LOAD;
          end
        end
        ST_SAMPLE:
        begin
          // The sampling phase is part of the counted conversion time.
          if (step_end) // R11
          begin
            state                   <= ST_STEP;
            cycle_cnt               <= STEP_LOAD;
            probe_bit               <= 10'h200;
            approximation_shift_reg <= 10'h200; // R17
          end
          else
            cycle_cnt <= cycle_cnt - 8'h01;
        end
        ST_STEP:
        begin
          if (step_end)
          begin
            approximation_shift_reg <= next_sar | (probe_bit >> 1); // R10 R17
            probe_bit               <= probe_bit >> 1;
            cycle_cnt               <= STEP_LOAD;
            if (probe_bit[0])
            begin
              // Software start goes again at once; trigger mode waits again.
              if (converter_mode_reg[MODE_TRIG_BIT])
                state <= ST_WAIT; // R13
              else
              begin
                state     <= ST_SAMPLE; // R12
                cycle_cnt <= SAMPLE_LOAD;
              end
            end
          end
          else
            cycle_cnt <= cycle_cnt - 8'h01;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // End-of-conversion holding stage: the result is committed one cycle later
  // unless a mode or channel write arrives in that cycle.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      eoc_pending   <= 1'b0;
      pending_value <= RESULT_RESET;
    end
    else
    begin
      eoc_pending   <= conv_end && run_ok && !cfg_write; // R07
      pending_value <= next_sar;
    end
  end

  // Result register and request pulse commit together.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      conversion_result_reg <= RESULT_RESET;
      done_irq_o            <= 1'b0;
    end
    else
    begin
      done_irq_o <= 1'b0;
      // A write directly after the result write drops the result.
      if (eoc_pending && !cfg_write) // R05 R09
      begin
        conversion_result_reg <= pending_value; // R16
        done_irq_o            <= 1'b1;
      end
    end
  end

  // Sticky done flag; set beats a software clear, channel writes leave it.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      conversion_done_flag <= 1'b0;
    else if (eoc_pending && !cfg_write)
      conversion_done_flag <= 1'b1; // R06 R07
    else if (req_i.wr && req_i.addr == OFS_FLAG && !req_i.wdata[0])
      conversion_done_flag <= 1'b0; // R08
  end

  assign done_flag_o = conversion_done_flag;

  ////////////////////////////////////////////////////////////////////////////
  // Read port; the read samples the result before this edge's commit.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= 8'h00;
    else if (req_i.rd)
    begin
      unique case (req_i.addr)
        OFS_MODE:    rdata_o <= converter_mode_reg;
        OFS_CHANNEL: rdata_o <= channel_select_reg;
        OFS_RESULT:  rdata_o <= conversion_result_reg[9:2]; // R03
        OFS_FLAG:    rdata_o <= {conversion_result_reg[1:0], 5'h00, conversion_done_flag};
        default:     rdata_o <= 8'h00;
      endcase
    end
    else
      rdata_o <= 8'h00;
  end

  // Front-end controls, registered.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      afe_o <= '0;
    else
    begin
      afe_o.sample  <= (state == ST_SAMPLE) && run_ok;
      afe_o.powered <= run_ok; // R02
      afe_o.channel <= channel_select_reg[3:0];
      afe_o.tap     <= (state == ST_STEP) ? approximation_shift_reg : 10'h000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  a_stop_halts: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R02
    !converter_mode_reg[MODE_RUN_BIT] |=> state == ST_IDLE)
    else $error("sequencer ran with run bit clear");
  a_standby_halts: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R01
    standby_sync |=> state == ST_IDLE)
    else $error("sequencer ran in stopping standby");
  a_done_with_result: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R16
    eoc_pending && !cfg_write |=> done_irq_o && conversion_result_reg == $past(pending_value))
    else $error("result and done pulse not together");
  a_cfg_discards: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R05
    eoc_pending && cfg_write |=> !done_irq_o)
    else $error("done raised after configuration write");
  a_read_old: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R03
    req_i.rd && req_i.addr == OFS_RESULT |=> rdata_o == $past(conversion_result_reg[9:2]))
    else $error("read did not return old result");
  a_trig_ignored: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R04
    state == ST_STEP && run_ok && !cfg_write && !conv_end |=> state != ST_SAMPLE)
    else $error("trigger restarted a running conversion");
  a_flag_kept: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R06
    conversion_done_flag && req_i.wr && req_i.addr == OFS_CHANNEL |=> conversion_done_flag)
    else $error("channel write cleared done flag");
  a_back_to_back: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R12
    conv_end && run_ok && !cfg_write && !converter_mode_reg[MODE_TRIG_BIT]
    |=> state == ST_SAMPLE)
    else $error("software mode did not restart");
  a_msb_first: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R17
    state == ST_SAMPLE && step_end && run_ok && !cfg_write |=> probe_bit == 10'h200)
    else $error("approximation did not start at msb");
  a_wait_edge: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R13
    state == ST_WAIT && !trig_edge && run_ok && !cfg_write |=> state == ST_WAIT)
    else $error("conversion started without a trigger edge");

endmodule : adc_conversion_control

// file: logic/adc_ctrl_pkg.sv
// Package of constants and types for the converter control block.
package adc_ctrl_pkg;

  // Register offsets on the plain register port.
  localparam logic [3:0] OFS_MODE    = 4'h0;
  localparam logic [3:0] OFS_CHANNEL = 4'h1;
  localparam logic [3:0] OFS_RESULT  = 4'h2;
  localparam logic [3:0] OFS_FLAG    = 4'h3;

  // Mode register field positions.
  localparam int MODE_RUN_BIT  = 7;
  localparam int MODE_TRIG_BIT = 6;
  localparam int MODE_EDGE_LO  = 4;

  // Reset values.
  localparam logic [7:0] MODE_RESET    = 8'h00;
  localparam logic [7:0] CHANNEL_RESET = 8'h00;
  localparam logic [9:0] RESULT_RESET  = 10'h000;

  // Converter figures.
  localparam int RESULT_BITS   = 10;
  localparam int CHANNEL_COUNT = 12;

  // Timing: sampling phase and one comparison step, in nanoseconds.
  localparam int CLK_PERIOD_NS   = 5;
  localparam int SAMPLE_TIME_NS  = 1000;
  localparam int STEP_TIME_NS    = 100;
  localparam int SAMPLE_CYCLES   = (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_CYCLES     = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SAMPLE_LOAD = 8'(SAMPLE_CYCLES - 1);
  localparam logic [7:0] STEP_LOAD   = 8'(STEP_CYCLES - 1);

  // Trigger edge selections.
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  // Sequencer states.
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_WAIT   = 4'b0010,
    ST_SAMPLE = 4'b0100,
    ST_STEP   = 4'b1000
  } seq_state_t;

  // Register port request.
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // Analog front-end controls.
  typedef struct packed {
    logic       sample;
    logic       powered;
    logic [3:0] channel;
    logic [9:0] tap;
  } afe_ctl_t;

endpackage : adc_ctrl_pkg

// file: test/adc_analog_model.sv
// Behavioural model of the analog inputs, sample-and-hold and comparator.
`timescale 1ns/1ps
module adc_analog_model
  import adc_ctrl_pkg::*;
(
  input  wire logic       clk_i,      // System clock.
  input  wire afe_ctl_t   afe_i,      // Front-end controls from the block.
  input  wire logic [9:0] base_i,     // Input level code set by the bench.
  output logic            cmp_above_o // Comparator output.
);
  logic [9:0] held = 10'h000;
  logic       wobble = 1'b0;

  // The hold node tracks the selected channel only while sampling.
  always @(posedge clk_i)
  begin
    if (afe_i.sample)
      held <= base_i ^ {6'h0, afe_i.channel};
    wobble <= ~wobble;
  end

  // A powered-down comparator gives no usable answer, so it toggles.
  assign cmp_above_o = afe_i.powered ? (held >= afe_i.tap) : wobble;
endmodule : adc_analog_model

// file: test/tb.sv
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb
  import adc_ctrl_pkg::*;
;
  logic       clk_sys_i = 1'b0;
  logic       rst_i = 1'b1;
  reg_req_t   req = '0;
  logic       standby_stop_i = 1'b0;
  logic       ext_trigger_i = 1'b0;
  logic       cmp_above_i;
  logic [7:0] rdata_o;
  afe_ctl_t   afe_o;
  logic       done_irq_o;
  logic       done_flag_o;
  logic [9:0] base = 10'h000;
  logic [7:0] seed = 8'h12;
  int         num_errors = 0;
  int         n_compared = 0;

  ////////////////////////////////////////////////////////////
  // Clock at 200 MHz.
  always #2.5 clk_sys_i = ~clk_sys_i;

  adc_conversion_control uut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata_o),
    .standby_stop_i(standby_stop_i), .ext_trigger_i(ext_trigger_i),
    .cmp_above_i(cmp_above_i), .afe_o(afe_o), .done_irq_o(done_irq_o),
    .done_flag_o(done_flag_o));

  adc_analog_model model (
    .clk_i(clk_sys_i), .afe_i(afe_o), .base_i(base), .cmp_above_o(cmp_above_i));

  ////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  // Ideal code for the model's input level on a channel.
  function automatic logic [9:0] exp_code(input logic [9:0] b, input logic [3:0] ch);
    return b ^ {6'h0, ch};
  endfunction : exp_code

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_i);
    req <= '0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_i);
    req <= '0;
    #1 d = rdata_o;
  endtask : rd

  task automatic get_res(output logic [9:0] r);
    logic [7:0] h;
    logic [7:0] l;
    rd(OFS_RESULT, h);
    rd(OFS_FLAG, l);
    r = {h, l[7:6]};
  endtask : get_res

  // Waits for the done pulse; a missing pulse ends the run.
  task automatic wait_irq(output int c);
    for (c = 1; c <= 2000; c++)
    begin
      @(posedge clk_sys_i);
      #1;
      if (done_irq_o === 1'b1)
        return;
    end
    num_errors++;
    $display("CHECK FAILED t=%0t no done pulse", $time);
    conclude();
  endtask : wait_irq

  task automatic count_irq(input int n, output int k);
    k = 0;
    repeat (n)
    begin
      @(posedge clk_sys_i);
      #1;
      if (done_irq_o === 1'b1)
        k++;
    end
  endtask : count_irq

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    logic [7:0] d;
    logic [9:0] r;
    logic [9:0] old;
    logic [3:0] ch;
    int c;
    int p;
    int k;
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    // Reset values, and an unmapped address, read as zero.
    for (int a = 0; a < 5; a++)
    begin
      rd(4'(a), d);
      `CHK(d, 8'h00)
    end
    $display("end reset test");
    // Software start on a random channel and level, back to back.
    seed = lfsr(seed);
    ch = 4'(seed % 12);
    seed = lfsr(seed);
    base = {seed, 2'b01};
    wr(OFS_CHANNEL, {4'h0, ch});
    wr(OFS_MODE, 8'h80);
    wait_irq(c);
    `CHK(done_flag_o, 1'b1)
    wait_irq(p);
    `CHK(p, SAMPLE_CYCLES + RESULT_BITS * STEP_CYCLES)
    get_res(r);
    `CHK(r, exp_code(base, ch))
    // A read taken at the result write returns the old value.
    wait_irq(c);
    old = exp_code(base, ch);
    seed = lfsr(seed);
    base = {seed, 2'b10};
    repeat (p - 2) @(posedge clk_sys_i);
    rd(OFS_RESULT, d);
    `CHK(done_irq_o, 1'b1)
    `CHK(d, old[9:2])
    get_res(r);
    `CHK(r, exp_code(base, ch))
    // A mode write on the commit edge discards that result.
    wait_irq(c);
    old = exp_code(base, ch);
    seed = lfsr(seed);
    base = {seed, 2'b11};
    repeat (p - 2) @(posedge clk_sys_i);
    wr(OFS_MODE, 8'h80);
    #1;
    `CHK(done_irq_o, 1'b0)
    get_res(r);
    `CHK(r, old)
    wait_irq(c);
    get_res(r);
    `CHK(r, exp_code(base, ch))
    $display("end software start test");
    // A channel change keeps the flag and restarts on the new input.
    repeat (100) @(posedge clk_sys_i);
    ch = 4'((ch + 5) % 12);
    wr(OFS_CHANNEL, {4'h0, ch});
    rd(OFS_FLAG, d);
    `CHK(d[0], 1'b1)
    wait_irq(c);
    get_res(r);
    `CHK(r, exp_code(base, ch))
    wr(OFS_FLAG, 8'h00);
    rd(OFS_FLAG, d);
    `CHK(d[0], 1'b0)
    // Clearing the run bit stops the conversion and powers down.
    repeat (100) @(posedge clk_sys_i);
    wr(OFS_MODE, 8'h00);
    repeat (2) @(posedge clk_sys_i);
    #1;
    `CHK(afe_o.powered, 1'b0)
    count_irq(600, k);
    `CHK(k, 0)
    // Standby holds conversion off until it ends.
    @(posedge clk_sys_i);
    standby_stop_i <= 1'b1;
    wr(OFS_MODE, 8'h80);
    count_irq(600, k);
    `CHK(k, 0)
    @(posedge clk_sys_i);
    standby_stop_i <= 1'b0;
    wait_irq(c);
    wr(OFS_MODE, 8'h00);
    $display("end stop test");
    // Hardware start for each edge kind; edges in mid-conversion are ignored.
    for (int e = 0; e < 3; e++)
    begin
      @(posedge clk_sys_i);
      ext_trigger_i <= (e == 0);
      repeat (10) @(posedge clk_sys_i);
      wr(OFS_MODE, {2'b11, 2'(e), 4'h0});
      count_irq(500, k);
      `CHK(k, 0)
      repeat (3)
      begin
        @(posedge clk_sys_i);
        ext_trigger_i <= ~ext_trigger_i;
        repeat (50) @(posedge clk_sys_i);
      end
      count_irq(1200, k);
      `CHK(k, 1)
      wr(OFS_MODE, 8'h00);
    end
    $display("end trigger test");
    conclude();
  end
endmodule : tb
